/* rtl/fpsc_pkg.sv */
package fpsc_pkg;

  // Register byte offsets.
  localparam logic [8:0] FPSC_OFF_SECURITY = 9'h010;
  localparam logic [8:0] FPSC_OFF_PROT_LOW = 9'h020;
  localparam logic [8:0] FPSC_OFF_PROT_HIGH = 9'h030;
  localparam logic [8:0] FPSC_OFF_OP_STATUS = 9'h100;
  localparam logic [8:0] FPSC_OFF_SWAP_STATUS = 9'h104;
  localparam logic [8:0] FPSC_OFF_AREA_SEL = 9'h140;
  localparam logic [8:0] FPSC_OFF_ABORT_CTRL = 9'h148;
  localparam logic [8:0] FPSC_OFF_STATUS_CLR = 9'h14C;
  localparam logic [8:0] FPSC_OFF_WCLK_DIV = 9'h150;
  localparam logic [8:0] FPSC_OFF_PROG_CNT = 9'h154;
  localparam logic [8:0] FPSC_OFF_ERASE_CNT = 9'h158;

  // Field positions.
  localparam int FPSC_SEC_BIT = 0;
  localparam int FPSC_READY_BIT = 0;
  localparam int FPSC_PAGE_LSB = 8;
  localparam int FPSC_BLKLOW_LSB = 17;
  localparam int FPSC_BLKHIGH_LSB = 16;
  localparam int FPSC_ABORT_FLAG_BIT = 24;
  localparam int FPSC_SWP_LSB = 0;
  localparam int FPSC_FLG_LSB = 2;
  localparam int FPSC_SIZE_LSB = 8;
  localparam int FPSC_REGION_ZERO_SELECT_LSB = 0;
  localparam int FPSC_REGION_ONE_SELECT_LSB = 4;

  // Codes and reset values.
  localparam logic [2:0] FPSC_ALL_ONES3 = 3'h7;
  localparam logic FPSC_SEC_RESET = 1'b1;
  localparam logic [1:0] FPSC_SWP_ACTIVE = 2'h1;
  localparam logic [1:0] FPSC_SWP_RELEASED = 2'h3;
  localparam logic [2:0] FPSC_SIZE_RESET = 3'h0;
  localparam logic [4:0] FPSC_DIV_RESET = 5'h00;
  localparam logic [1:0] FPSC_PROG_RESET = 2'h0;
  localparam logic [3:0] FPSC_ERASE_RESET = 4'h6;
  localparam logic [31:0] FPSC_RD_UNMAPPED = 32'h0000_0000;
  localparam logic [31:0] FPSC_PROT_HIGH_ONE = 32'h0000_0001;

  // Swap region sizes as address bit counts: 4K,8K,16K,32K,512K.
  localparam logic [4:0] FPSC_SZ_4K = 5'h0C;
  localparam logic [4:0] FPSC_SZ_8K = 5'h0D;
  localparam logic [4:0] FPSC_SZ_16K = 5'h0E;
  localparam logic [4:0] FPSC_SZ_32K = 5'h0F;
  localparam logic [4:0] FPSC_SZ_512K = 5'h13;
  localparam int FPSC_FADDR_W = 20;

  typedef enum logic [2:0] {
    FPSC_CMD_PROGRAM,
    FPSC_CMD_CHIP_ERASE,
    FPSC_CMD_AREA_ERASE,
    FPSC_CMD_SWAP,
    FPSC_CMD_PROT_ERASE
  } fpsc_cmd_t;

  typedef struct packed {
    logic valid;
    fpsc_cmd_t cmd;
    logic area;
    logic swap_set;
    logic swap_release;
    logic [2:0] size;
    logic [5:0] flags;
  } fpsc_req_t;

  typedef struct packed {
    logic ready;
    logic fail;
    logic [14:0] blk_low;
    logic [7:0] page;
    logic [15:0] blk_high;
  } fpsc_core_t;

endpackage

/* rtl/fpsc_swap_map.sv */
`timescale 1ns/1ps
module fpsc_swap_map
  import fpsc_pkg::*;
(
  input wire logic [1:0] swap_state,
  input wire logic [2:0] swap_size,
  input wire logic [FPSC_FADDR_W-1:0] addr_in,
  output logic [FPSC_FADDR_W-1:0] addr_out
);

  logic [4:0] bits_w;

  always_comb begin
    case (swap_size)
      3'h0: bits_w = FPSC_SZ_4K;
      3'h1: bits_w = FPSC_SZ_8K;
      3'h2: bits_w = FPSC_SZ_16K;
      3'h3: bits_w = FPSC_SZ_32K;
      default: bits_w = FPSC_SZ_512K;
    endcase
  end

  // Regions below twice the size swap halves while swapping.
  always_comb begin
    addr_out = addr_in;
    if (swap_state == FPSC_SWP_ACTIVE && (addr_in >> (bits_w + 5'h01)) == '0) begin
      addr_out = addr_in ^ (FPSC_FADDR_W'(1) << bits_w);
    end
  end

endmodule // fpsc_swap_map

/* rtl/fpsc_cmd_gate.sv */
`timescale 1ns/1ps
module fpsc_cmd_gate
  import fpsc_pkg::*;
(
  input wire fpsc_req_t req,
  input wire logic [2:0] region_zero_select_sel,
  input wire logic [2:0] region_one_select_sel,
  input wire logic ready,
  input wire logic secured,
  output logic accept
);

  logic area_ok;

  always_comb begin
    if (req.cmd == FPSC_CMD_CHIP_ERASE) begin
      area_ok = (region_zero_select_sel == FPSC_ALL_ONES3) && (region_one_select_sel == FPSC_ALL_ONES3);
    end else if (req.area) begin
      area_ok = region_one_select_sel == FPSC_ALL_ONES3;
    end else begin
      area_ok = region_zero_select_sel == FPSC_ALL_ONES3;
    end
  end

  // Busy or unselected area cancels the command.
  assign accept = req.valid && ready && area_ok && !secured;

endmodule // fpsc_cmd_gate

/* rtl/fpsc_ctrl.sv */
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - Security bit 0, resets one, rest zero.
// - Security reset also by deep stop release.
// - Blocks 1-15 protect flags, read-only.
// - Block 0 pages protect flags bits 15-8.
// - Ready flag low during automatic operation.
// - Failure keeps busy until abort.
// - Commands while busy are not taken.
// - High protect register, bit 0 one.
// - Abort while busy sets sticky abort flag bit 24.
// - Swap size field bits 10-8.
// - Swap state bits 1-0, 01 swapping.
// - Software flag field bits 7-2.
// - Protect bit erase clears swap status.
// - Area one selected only by 111.
// - Area zero selected only by 111.
// - Unselected area cancels the command.
// - Abort field 111 aborts, reads back.
// - Swapping exchanges the two low regions.
// - Swap command sets state, and size for codes 0-4 only.
// - Security active needs all protect bits.
// - Status clear 111 clears abort flag.
module fpsc_ctrl
  import fpsc_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic DEEP_STOP_RELEASE,
  // Avalon-MM slave.
  input wire logic [8:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Flash core side.
  input wire fpsc_req_t CMD_REQ,
  input wire fpsc_core_t CORE_STAT,
  input wire logic [FPSC_FADDR_W-1:0] FETCH_ADDR,
  output logic CMD_ACCEPT,
  output logic CORE_ABORT,
  output logic SECURITY_ACTIVE,
  output logic [FPSC_FADDR_W-1:0] ARRAY_ADDR,
  output logic [4:0] WCLK_DIV,
  output logic [1:0] PROG_CNT,
  output logic [3:0] ERASE_CNT
);

  typedef enum logic [1:0] {FPSC_IDLE, FPSC_ANSWER} fpsc_bus_t;

  fpsc_bus_t bus_q;
  logic sec_q;
  logic abort_flag_q;
  logic [2:0] abort_field_q;
  logic [2:0] clear_field_q;
  logic [2:0] region_zero_select_q;
  logic [2:0] region_one_select_q;
  logic [1:0] swp_q;
  logic [5:0] flg_q;
  logic [2:0] size_q;
  logic [4:0] div_q;
  logic [1:0] prog_q;
  logic [3:0] erase_q;
  logic busy_q;
  logic accept_q;
  logic abort_pulse_q;
  logic secured_q;
  logic [FPSC_FADDR_W-1:0] array_addr_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_take;
  logic rd_take;
  logic accept_w;
  logic ready_w;
  logic all_prot_w;
  logic [FPSC_FADDR_W-1:0] map_addr_w;

  // One wait cycle: request seen while idle stalls, answered next edge.
  assign wr_take = AVS_WRITE && bus_q == FPSC_ANSWER;
  assign rd_take = AVS_READ && bus_q == FPSC_ANSWER;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bus_q <= FPSC_IDLE;
    end else begin
      case (bus_q)
        FPSC_IDLE: bus_q <= (AVS_READ || AVS_WRITE) ? FPSC_ANSWER : FPSC_IDLE;
        FPSC_ANSWER: bus_q <= FPSC_IDLE;
        default: bus_q <= FPSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= !(bus_q == FPSC_IDLE && (AVS_READ || AVS_WRITE));
    end
  end

  // Security bit, reinitialised by reset and by deep stop release.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sec_q <= FPSC_SEC_RESET;
    end else if (DEEP_STOP_RELEASE) begin
      sec_q <= FPSC_SEC_RESET;
    end else if (wr_take && AVS_ADDRESS == FPSC_OFF_SECURITY) begin
      sec_q <= AVS_WRITEDATA[FPSC_SEC_BIT];
    end
  end

  // Security function needs the bit and every protect bit set.
  assign all_prot_w = &CORE_STAT.blk_low && &CORE_STAT.page && &CORE_STAT.blk_high;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      secured_q <= 1'b0;
    end else begin
      secured_q <= sec_q && all_prot_w;
    end
  end

  // Area selection register.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      region_zero_select_q <= '0;
      region_one_select_q <= '0;
    end else if (wr_take && AVS_ADDRESS == FPSC_OFF_AREA_SEL) begin
      region_zero_select_q <= AVS_WRITEDATA[FPSC_REGION_ZERO_SELECT_LSB +: 3];
      region_one_select_q <= AVS_WRITEDATA[FPSC_REGION_ONE_SELECT_LSB +: 3];
    end
  end

  // Abort control and status clear fields read back as written.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      abort_field_q <= '0;
      abort_pulse_q <= 1'b0;
    end else begin
      abort_pulse_q <= 1'b0;
      if (wr_take && AVS_ADDRESS == FPSC_OFF_ABORT_CTRL) begin
        abort_field_q <= AVS_WRITEDATA[2:0];
        abort_pulse_q <= AVS_WRITEDATA[2:0] == FPSC_ALL_ONES3;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      clear_field_q <= '0;
    end else if (wr_take && AVS_ADDRESS == FPSC_OFF_STATUS_CLR) begin
      clear_field_q <= AVS_WRITEDATA[2:0];
    end
  end

  // Sticky abort flag; a new abort wins over a clear in the same cycle.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      abort_flag_q <= 1'b0;
    end else if (abort_pulse_q && busy_q) begin
      abort_flag_q <= 1'b1;
    end else if (wr_take && AVS_ADDRESS == FPSC_OFF_STATUS_CLR && AVS_WRITEDATA[2:0] == FPSC_ALL_ONES3) begin
      abort_flag_q <= 1'b0;
    end
  end

  // Busy from acceptance until the core ends normally or is aborted.
  fpsc_cmd_gate u_gate (
    .req(CMD_REQ),
    .region_zero_select_sel(region_zero_select_q),
    .region_one_select_sel(region_one_select_q),
    .ready(ready_w),
    .secured(secured_q),
    .accept(accept_w)
  );

  assign ready_w = !busy_q;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_q <= 1'b0;
    end else if (abort_pulse_q) begin
      busy_q <= 1'b0;
    end else if (accept_w) begin
      busy_q <= 1'b1;
    end else if (busy_q && CORE_STAT.ready && !CORE_STAT.fail) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      accept_q <= 1'b0;
      CORE_ABORT <= 1'b0;
    end else begin
      accept_q <= accept_w;
      CORE_ABORT <= abort_pulse_q;
    end
  end

  assign CMD_ACCEPT = accept_q;

  // Swap status: set by swap command, cleared by protect bit erase.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      swp_q <= '0;
      flg_q <= '0;
      size_q <= FPSC_SIZE_RESET;
    end else if (accept_w && CMD_REQ.cmd == FPSC_CMD_PROT_ERASE) begin
      swp_q <= '0;
      flg_q <= '0;
      size_q <= FPSC_SIZE_RESET;
    end else if (accept_w && CMD_REQ.cmd == FPSC_CMD_SWAP) begin
      if (CMD_REQ.swap_set) begin
        swp_q[0] <= 1'b1;
      end
      if (CMD_REQ.swap_release) begin
        swp_q[1] <= 1'b1;
      end
      if (CMD_REQ.size <= 3'h4) begin
        size_q <= CMD_REQ.size;
      end
      flg_q <= CMD_REQ.flags;
    end
  end

  fpsc_swap_map u_map (
    .swap_state(swp_q),
    .swap_size(size_q),
    .addr_in(FETCH_ADDR),
    .addr_out(map_addr_w)
  );

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      array_addr_q <= '0;
    end else begin
      array_addr_q <= map_addr_w;
    end
  end

  assign ARRAY_ADDR = array_addr_q;
  assign SECURITY_ACTIVE = secured_q;

  // Timing count registers passed on to the core.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_q <= FPSC_DIV_RESET;
      prog_q <= FPSC_PROG_RESET;
      erase_q <= FPSC_ERASE_RESET;
    end else if (wr_take) begin
      case (AVS_ADDRESS)
        FPSC_OFF_WCLK_DIV: div_q <= AVS_WRITEDATA[4:0];
        FPSC_OFF_PROG_CNT: prog_q <= AVS_WRITEDATA[1:0];
        FPSC_OFF_ERASE_CNT: erase_q <= AVS_WRITEDATA[3:0];
        default: ;
      endcase
    end
  end

  assign WCLK_DIV = div_q;
  assign PROG_CNT = prog_q;
  assign ERASE_CNT = erase_q;

  // Read mux; reserved bits are zero and unmapped reads return zero.
  always_comb begin
    rdata_d = FPSC_RD_UNMAPPED;
    case (AVS_ADDRESS)
      FPSC_OFF_SECURITY: rdata_d[FPSC_SEC_BIT] = sec_q;
      FPSC_OFF_PROT_LOW: begin
        rdata_d[FPSC_BLKLOW_LSB +: 15] = CORE_STAT.blk_low;
        rdata_d[FPSC_PAGE_LSB +: 8] = CORE_STAT.page;
        rdata_d[FPSC_READY_BIT] = ready_w;
      end
      FPSC_OFF_PROT_HIGH: rdata_d = {CORE_STAT.blk_high, 16'h0000} | FPSC_PROT_HIGH_ONE;
      FPSC_OFF_OP_STATUS: rdata_d[FPSC_ABORT_FLAG_BIT] = abort_flag_q;
      FPSC_OFF_SWAP_STATUS: begin
        rdata_d[FPSC_SIZE_LSB +: 3] = size_q;
        rdata_d[FPSC_FLG_LSB +: 6] = flg_q;
        rdata_d[FPSC_SWP_LSB +: 2] = swp_q;
      end
      FPSC_OFF_AREA_SEL: begin
        rdata_d[FPSC_REGION_ONE_SELECT_LSB +: 3] = region_one_select_q;
        rdata_d[FPSC_REGION_ZERO_SELECT_LSB +: 3] = region_zero_select_q;
      end
      FPSC_OFF_ABORT_CTRL: rdata_d[2:0] = abort_field_q;
      FPSC_OFF_STATUS_CLR: rdata_d[2:0] = clear_field_q;
      FPSC_OFF_WCLK_DIV: rdata_d[4:0] = div_q;
      FPSC_OFF_PROG_CNT: rdata_d[1:0] = prog_q;
      FPSC_OFF_ERASE_CNT: rdata_d[3:0] = erase_q;
      default: rdata_d = FPSC_RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= '0;
    end else if (bus_q == FPSC_IDLE && AVS_READ) begin
      rdata_q <= rdata_d;
    end
  end

  assign AVS_READDATA = rdata_q;

  // Assertions.
  sec_reset_val_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    DEEP_STOP_RELEASE |=> sec_q) else $error("security bit not reinitialised");
  busy_block_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    busy_q |-> !accept_w) else $error("command taken while busy");
  area_cancel_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (CMD_REQ.valid && !CMD_REQ.area && region_zero_select_q != FPSC_ALL_ONES3) |-> !accept_w)
    else $error("unselected area command taken");
  fail_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (busy_q && CORE_STAT.fail && !abort_pulse_q) |=> busy_q) else $error("busy lost on failure");
  abort_ready_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    abort_pulse_q |=> ready_w) else $error("abort did not restore ready");
  abort_flag_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (abort_pulse_q && busy_q) |=> abort_flag_q) else $error("abort flag not set");
  clear_flag_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (wr_take && AVS_ADDRESS == FPSC_OFF_STATUS_CLR && AVS_WRITEDATA[2:0] == FPSC_ALL_ONES3 &&
     !(abort_pulse_q && busy_q)) |=> !abort_flag_q) else $error("abort flag not cleared");
  swap_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (accept_w && CMD_REQ.cmd == FPSC_CMD_PROT_ERASE) |=> (swp_q == 2'h0 && size_q == 3'h0))
    else $error("swap status not reinitialised");
  abort_pulse_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (wr_take && AVS_ADDRESS == FPSC_OFF_ABORT_CTRL && AVS_WRITEDATA[2:0] == 3'h7) |=> ##1 CORE_ABORT)
    else $error("abort not forwarded");
  secure_need_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    secured_q |-> $past(sec_q)) else $error("secured without bit");

  swap_seen_c: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) swp_q == FPSC_SWP_ACTIVE);
  abort_seen_c: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) abort_pulse_q && busy_q);
  accept_seen_c: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) accept_w);

endmodule // fpsc_ctrl

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import fpsc_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic deep_stop = 1'b0;
  logic [8:0] avs_address = 9'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  fpsc_req_t cmd_req = '0;
  fpsc_core_t core_stat = '{ready: 1'b1, default: '0};
  logic [FPSC_FADDR_W-1:0] fetch_addr = '0;
  logic cmd_accept;
  logic core_abort;
  logic security_active;
  logic [FPSC_FADDR_W-1:0] array_addr;
  logic [4:0] wclk_div;
  logic [1:0] prog_cnt;
  logic [3:0] erase_cnt;
  int err_total = 0;
  int num_checks = 0;
  int seed = 32'h3895;
  int aborts = 0;
  int n;
  int k;
  logic [31:0] rd;
  logic [31:0] r;
  logic [5:0] f;

  always #5 sys_clk = ~sys_clk;

  // Counts abort pulses sent to the flash core.
  always @(posedge sys_clk) begin
    if (core_abort === 1'b1) aborts++;
  end

  fpsc_ctrl dut_u (
    .SYS_CLK(sys_clk),
    .RESET_N(reset_n),
    .DEEP_STOP_RELEASE(deep_stop),
    .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read),
    .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest),
    .CMD_REQ(cmd_req),
    .CORE_STAT(core_stat),
    .FETCH_ADDR(fetch_addr),
    .CMD_ACCEPT(cmd_accept),
    .CORE_ABORT(core_abort),
    .SECURITY_ACTIVE(security_active),
    .ARRAY_ADDR(array_addr),
    .WCLK_DIV(wclk_div),
    .PROG_CNT(prog_cnt),
    .ERASE_CNT(erase_cnt)
  );

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One Avalon-MM access, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      w++;
    end while (avs_waitrequest !== 1'b0 && w < 100);
    if (w >= 100) begin
      err_total++;
      $display("CHECK FAILED at %0t: bus wait expired", $time);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdchk(input logic [8:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, exp, what);
  endtask

  // Presents one command for a cycle and counts accept pulses that follow.
  task automatic issue(input fpsc_cmd_t c, input logic ar, input logic st, input logic rl,
                       input logic [2:0] sz, input logic [5:0] fl);
    fpsc_req_t q;
    q = '{valid: 1'b1, cmd: c, area: ar, swap_set: st, swap_release: rl, size: sz, flags: fl};
    n = 0;
    @(posedge sys_clk);
    cmd_req <= q;
    @(posedge sys_clk);
    cmd_req.valid <= 1'b0;
    repeat (4) begin
      @(posedge sys_clk);
      if (cmd_accept === 1'b1) n++;
    end
  endtask

  function automatic int size_bits(input logic [2:0] sz);
    return (sz == 3'h4) ? 19 : 12 + int'(sz);
  endfunction

  function automatic logic [19:0] swapped(input logic [19:0] a, input logic [1:0] st, input logic [2:0] sz);
    int b;
    b = size_bits(sz);
    if (st == 2'h1 && int'(a) < (2 << b)) return a ^ 20'(1 << b);
    return a;
  endfunction

  task automatic fetch_check(input logic [1:0] st, input logic [2:0] sz);
    int b;
    logic [19:0] a;
    b = size_bits(sz);
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 20'((1 << b) - 1) : 20'({$random(seed)} % (4 << b));
      @(posedge sys_clk);
      fetch_addr <= a;
      repeat (2) @(posedge sys_clk);
      check(32'(array_addr), 32'(swapped(a, st, sz)), "fetch map");
    end
  endtask

  initial begin
    #100_000;
    err_total++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    rdchk(FPSC_OFF_SECURITY, 32'h0000_0001, "security reset");
    rdchk(FPSC_OFF_PROT_HIGH, FPSC_PROT_HIGH_ONE, "prot high reset");
    rdchk(FPSC_OFF_PROT_LOW, 32'h0000_0001, "ready at idle");
    rdchk(FPSC_OFF_OP_STATUS, 32'h0000_0000, "status reset");
    rdchk(FPSC_OFF_SWAP_STATUS, 32'h0000_0000, "swap reset");
    rdchk(FPSC_OFF_AREA_SEL, 32'h0000_0000, "area reset");
    rdchk(FPSC_OFF_ABORT_CTRL, 32'h0000_0000, "abort reset");
    rdchk(FPSC_OFF_ERASE_CNT, {28'h0000000, FPSC_ERASE_RESET}, "erase reset");
    rdchk(9'h1FC, FPSC_RD_UNMAPPED, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      bus(1'b1, FPSC_OFF_SECURITY, r);
      rdchk(FPSC_OFF_SECURITY, {31'h0, r[0]}, "security rw");
      bus(1'b1, FPSC_OFF_AREA_SEL, r);
      rdchk(FPSC_OFF_AREA_SEL, r & 32'h0000_0077, "area rw");
      bus(1'b1, FPSC_OFF_WCLK_DIV, r);
      bus(1'b1, FPSC_OFF_PROG_CNT, r);
      bus(1'b1, FPSC_OFF_ERASE_CNT, r);
      bus(1'b1, FPSC_OFF_PROT_LOW, ~r);
      bus(1'b1, FPSC_OFF_SWAP_STATUS, ~r);
      core_stat <= '{ready: 1'b1, fail: 1'b0, blk_low: r[30:16], page: r[15:8], blk_high: ~r[31:16]};
      rdchk(FPSC_OFF_PROT_LOW, {r[30:16], 1'b0, r[15:8], 7'h00, 1'b1}, "prot low");
      rdchk(FPSC_OFF_PROT_HIGH, {~r[31:16], 15'h0000, 1'b1}, "prot high");
      rdchk(FPSC_OFF_SWAP_STATUS, 32'h0000_0000, "swap read only");
      rdchk(FPSC_OFF_WCLK_DIV, r & 32'h0000_001F, "div rw");
      rdchk(FPSC_OFF_PROG_CNT, r & 32'h0000_0003, "prog rw");
      rdchk(FPSC_OFF_ERASE_CNT, r & 32'h0000_000F, "erase rw");
      check({wclk_div, prog_cnt, erase_cnt}, {r[4:0], r[1:0], r[3:0]}, "timing outs");
    end
    $display("test registers done");
    bus(1'b1, FPSC_OFF_SECURITY, 32'h0000_0000);
    rdchk(FPSC_OFF_SECURITY, 32'h0000_0000, "security clear");
    @(posedge sys_clk);
    deep_stop <= 1'b1;
    @(posedge sys_clk);
    deep_stop <= 1'b0;
    rdchk(FPSC_OFF_SECURITY, 32'h0000_0001, "deep stop init");
    core_stat <= '{ready: 1'b1, fail: 1'b0, default: '1};
    bus(1'b1, FPSC_OFF_AREA_SEL, 32'h0000_0077);
    repeat (3) @(posedge sys_clk);
    check(32'(security_active), 32'h1, "secured");
    issue(FPSC_CMD_PROGRAM, 1'b0, 1'b0, 1'b0, 3'h0, 6'h00);
    check(n, 0, "secured refusal");
    core_stat.page <= 8'hFE;
    repeat (3) @(posedge sys_clk);
    check(32'(security_active), 32'h0, "one page open");
    core_stat <= '{ready: 1'b1, default: '0};
    $display("test security done");
    bus(1'b1, FPSC_OFF_AREA_SEL, 32'h0000_0007);
    rdchk(FPSC_OFF_AREA_SEL, 32'h0000_0007, "area poll");
    issue(FPSC_CMD_PROGRAM, 1'b1, 1'b0, 1'b0, 3'h0, 6'h00);
    check(n, 0, "area one unselected");
    issue(FPSC_CMD_CHIP_ERASE, 1'b0, 1'b0, 1'b0, 3'h0, 6'h00);
    check(n, 0, "chip erase one area");
    core_stat.ready <= 1'b0;
    issue(FPSC_CMD_PROGRAM, 1'b0, 1'b0, 1'b0, 3'h0, 6'h00);
    check(n, 1, "area zero program");
    rdchk(FPSC_OFF_PROT_LOW, 32'h0000_0000, "busy");
    issue(FPSC_CMD_PROGRAM, 1'b0, 1'b0, 1'b0, 3'h0, 6'h00);
    check(n, 0, "busy refusal");
    core_stat.ready <= 1'b1;
    core_stat.fail <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rdchk(FPSC_OFF_PROT_LOW, 32'h0000_0000, "failed stays busy");
    k = aborts;
    bus(1'b1, FPSC_OFF_ABORT_CTRL, 32'h0000_0007);
    repeat (4) @(posedge sys_clk);
    check(aborts - k, 1, "abort pulse");
    core_stat.fail <= 1'b0;
    rdchk(FPSC_OFF_ABORT_CTRL, 32'h0000_0007, "abort readback");
    rdchk(FPSC_OFF_PROT_LOW, 32'h0000_0001, "ready after abort");
    rdchk(FPSC_OFF_OP_STATUS, 32'h0100_0000, "abort flag");
    bus(1'b1, FPSC_OFF_ABORT_CTRL, 32'h0000_0000);
    bus(1'b1, FPSC_OFF_STATUS_CLR, 32'hFFFF_FFFF);
    rdchk(FPSC_OFF_STATUS_CLR, 32'h0000_0007, "clear readback");
    rdchk(FPSC_OFF_OP_STATUS, 32'h0000_0000, "flag cleared");
    bus(1'b1, FPSC_OFF_AREA_SEL, 32'h0000_0077);
    issue(FPSC_CMD_CHIP_ERASE, 1'b0, 1'b0, 1'b0, 3'h0, 6'h00);
    check(n, 1, "chip erase both areas");
    repeat (3) @(posedge sys_clk);
    rdchk(FPSC_OFF_PROT_LOW, 32'h0000_0001, "erase done");
    $display("test commands done");
    // Each round ends with release and protect bit erase, so the next swap starts from 00.
    for (int i = 0; i < 5; i++) begin
      f = 6'($random(seed));
      issue(FPSC_CMD_SWAP, 1'b0, 1'b1, 1'b0, 3'(i), f);
      check(n, 1, "swap accepted");
      repeat (3) @(posedge sys_clk);
      rdchk(FPSC_OFF_SWAP_STATUS, {21'h0, 3'(i), f, FPSC_SWP_ACTIVE}, "swapping");
      fetch_check(FPSC_SWP_ACTIVE, 3'(i));
      issue(FPSC_CMD_SWAP, 1'b0, 1'b0, 1'b1, 3'(i), f);
      repeat (3) @(posedge sys_clk);
      rdchk(FPSC_OFF_SWAP_STATUS, {21'h0, 3'(i), f, FPSC_SWP_RELEASED}, "released");
      fetch_check(FPSC_SWP_RELEASED, 3'(i));
      issue(FPSC_CMD_PROT_ERASE, 1'b0, 1'b0, 1'b0, 3'h0, 6'h00);
      repeat (3) @(posedge sys_clk);
      rdchk(FPSC_OFF_SWAP_STATUS, 32'h0000_0000, "prot erase init");
      fetch_check(2'h0, 3'h0);
    end
    issue(FPSC_CMD_SWAP, 1'b0, 1'b0, 1'b0, 3'h5, 6'h00);
    repeat (3) @(posedge sys_clk);
    rdchk(FPSC_OFF_SWAP_STATUS, 32'h0000_0000, "prohibited size ignored");
    $display("test swap done");
    final_report();
  end
endmodule // testbench
